// file: cpu_quirk_core.sv
// Retire-stage model of the jump, trace, erase-step and pop-multiple anomalies
// What this block does
// - Single-stepping over a segment D erase leaves a corrupted program counter.
// - Trace records the loop start after a false-condition loop exit.
// - The wrong trace entry never changes the executed program counter.
// - After a jump, following word 0X40h or 0X50h adds 2 to PC.
// - The extra advance ignores whether that word is opcode or data.
// - Pop-multiple makes one extra read right after the last SP increment.
// - A vacant stray read sets the vacant flag, interrupt if enabled.
// - The stray read hits vacant memory at or above the stack top.
`timescale 1ns/1ps
`include "cpu_quirk_map.svh"
module cpu_quirk_core
    import cpu_quirk_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Retired instruction
    input wire logic retValid,
    input wire instr_kind_type retKind,
    input wire logic [19:0] retPc,
    input wire logic [19:0] retNextPc,
    input wire logic [15:0] followWord,
    input wire logic condFalse,
    input wire logic [19:0] loopStart,
    input wire logic [19:0] popMultiFinalSp,
    // Debug control
    input wire logic debugStep,
    // Memory answer for the stray read
    input wire logic rdVacant,
    // Vacant flag control
    input wire logic vacantFlagClear,
    input wire logic vacantIrqEnable,
    // Program counter
    output logic [19:0] pc_q,
    // Trace buffer entry
    output logic traceValid_q,
    output logic [19:0] traceAddr_q,
    // Stray read and vacant flag
    output logic strayRdReq_q,
    output logic [19:0] strayRdAddr_q,
    output logic vacantFlag_q,
    output logic vacantIrq_q
);
    stray_read_if sr();

    logic [19:0] pc_d;
    logic traceValid_d;
    logic [19:0] traceAddr_d;
    logic loopExit_q, loopExit_d;
    logic [19:0] loopStart_q, loopStart_d;
    logic isJump;
    logic followHit;
    logic eraseStep;

    always_comb
    begin
        isJump = retValid && (retKind == KIND_JUMP || retKind == KIND_COND_JUMP);
        // Opcode or data alike: only the bit pattern of the word counts
        // pattern only
        followHit = ((followWord & `QUIRK_FOLLOW_MASK) == `QUIRK_FOLLOW_PAT_A) ||
                    ((followWord & `QUIRK_FOLLOW_MASK) == `QUIRK_FOLLOW_PAT_B);
        // Free-running erase retires cleanly; only a debugger step corrupts
        eraseStep = retValid && debugStep && retKind == KIND_ERASE_INFO_D;
        pc_d = pc_q;
        if (eraseStep)
        begin
            pc_d = retNextPc ^ `QUIRK_CORRUPT_MASK;
        end
        else if (isJump && followHit)
        begin
            pc_d = retNextPc + `QUIRK_PC_STEP;
        end
        else if (retValid)
        begin
            pc_d = retNextPc;
        end
        traceValid_d = retValid;
        traceAddr_d = traceAddr_q;
        loopExit_d = loopExit_q;
        loopStart_d = loopStart_q;
        // Only the recorded address is bent; pc_d never reads loopExit_q
        if (retValid)
        begin
            traceAddr_d = loopExit_q ? loopStart_q : retPc;
            loopExit_d = retKind == KIND_COND_JUMP && condFalse;
            loopStart_d = loopStart;
        end
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            pc_q <= `QUIRK_PC_RESET;
            traceValid_q <= 1'b0;
            traceAddr_q <= `QUIRK_ADDR_RESET;
            loopExit_q <= 1'b0;
            loopStart_q <= `QUIRK_ADDR_RESET;
        end
        else
        begin
            pc_q <= pc_d;
            traceValid_q <= traceValid_d;
            traceAddr_q <= traceAddr_d;
            loopExit_q <= loopExit_d;
            loopStart_q <= loopStart_d;
        end
    end

    assign sr.popMultiDone = retValid && retKind == KIND_POP_MULTI;
    assign sr.finalSp = popMultiFinalSp;

    stray_read_unit strayUnit
    (
        .clk(clk),
        .rst_n(rst_n),
        .sr(sr.unit),
        .rdVacant(rdVacant),
        .vacantFlagClear(vacantFlagClear),
        .vacantIrqEnable(vacantIrqEnable)
    );

    // Unit outputs are already flops; no extra delay added
    assign strayRdReq_q = sr.rdReq;
    assign strayRdAddr_q = sr.rdAddr;
    assign vacantFlag_q = sr.vacantFlag;
    assign vacantIrq_q = sr.vacantIrq;

    property p_erase_step_corrupts;
        @(posedge clk) disable iff (!rst_n)
        retValid && debugStep && retKind == KIND_ERASE_INFO_D
            |=> pc_q == ($past(retNextPc) ^ `QUIRK_CORRUPT_MASK);
    endproperty
    a_erase_step_corrupts: assert property (p_erase_step_corrupts)
        else $error("stepped erase did not corrupt pc");

    property p_erase_free_run_clean;
        @(posedge clk) disable iff (!rst_n)
        retValid && !debugStep && retKind == KIND_ERASE_INFO_D |=> pc_q == $past(retNextPc);
    endproperty
    a_erase_free_run_clean: assert property (p_erase_free_run_clean)
        else $error("erase outside debug changed pc");

    property p_jump_extra_step;
        @(posedge clk) disable iff (!rst_n)
        isJump && followHit |=> pc_q == $past(retNextPc) + `QUIRK_PC_STEP;
    endproperty
    a_jump_extra_step: assert property (p_jump_extra_step)
        else $error("jump over pattern word missed extra advance");

    property p_jump_plain;
        @(posedge clk) disable iff (!rst_n)
        isJump && !followHit |=> pc_q == $past(retNextPc);
    endproperty
    a_jump_plain: assert property (p_jump_plain)
        else $error("jump without pattern word advanced wrongly");

    property p_loop_exit_trace;
        @(posedge clk) disable iff (!rst_n)
        retValid && retKind == KIND_COND_JUMP && condFalse ##1 retValid
            |=> traceAddr_q == $past(loopStart, 2);
    endproperty
    a_loop_exit_trace: assert property (p_loop_exit_trace)
        else $error("loop exit trace entry not loop start");

    property p_exit_pc_correct;
        @(posedge clk) disable iff (!rst_n)
        retValid && retKind == KIND_COND_JUMP && condFalse && !followHit
            |=> pc_q == $past(retNextPc);
    endproperty
    a_exit_pc_correct: assert property (p_exit_pc_correct)
        else $error("loop exit changed execution");

    property p_retire_makes_trace;
        @(posedge clk) disable iff (!rst_n)
        retValid |=> traceValid_q;
    endproperty
    a_retire_makes_trace: assert property (p_retire_makes_trace)
        else $error("retired instruction left no trace entry");

    property p_idle_no_trace;
        @(posedge clk) disable iff (!rst_n)
        !retValid |=> !traceValid_q;
    endproperty
    a_idle_no_trace: assert property (p_idle_no_trace)
        else $error("trace entry without a retirement");

    property p_plain_trace_entry;
        @(posedge clk) disable iff (!rst_n)
        retValid && !loopExit_q |=> traceAddr_q == $past(retPc);
    endproperty
    a_plain_trace_entry: assert property (p_plain_trace_entry)
        else $error("ordinary trace entry not the retired address");

    property p_idle_pc_hold;
        @(posedge clk) disable iff (!rst_n)
        !retValid |=> pc_q == $past(pc_q);
    endproperty
    a_idle_pc_hold: assert property (p_idle_pc_hold)
        else $error("pc moved without a retirement");

    property p_trace_keeps_execution;
        @(posedge clk) disable iff (!rst_n)
        retValid && loopExit_q && !eraseStep && !(isJump && followHit)
            |=> pc_q == $past(retNextPc);
    endproperty
    a_trace_keeps_execution: assert property (p_trace_keeps_execution)
        else $error("bent trace entry changed execution");

    property p_pop_multi_pc_clean;
        @(posedge clk) disable iff (!rst_n)
        retValid && retKind == KIND_POP_MULTI |=> pc_q == $past(retNextPc);
    endproperty
    a_pop_multi_pc_clean: assert property (p_pop_multi_pc_clean)
        else $error("stray read disturbed execution");
endmodule

// file: cpu_quirk_map.svh
// Constants for the jump, erase-step and pop-multiple execution anomalies
`ifndef CPU_QUIRK_MAP_SVH
`define CPU_QUIRK_MAP_SVH
`define QUIRK_PC_RESET 20'h0_0000
`define QUIRK_PC_STEP 20'h0_0002
`define QUIRK_FOLLOW_MASK 16'hF0FF
`define QUIRK_FOLLOW_PAT_A 16'h0040
`define QUIRK_FOLLOW_PAT_B 16'h0050
`define QUIRK_CORRUPT_MASK 20'hA_5A5A
`define QUIRK_ADDR_RESET 20'h0_0000
`endif

// file: cpu_quirk_pkg.sv
// Types shared by the anomaly model
package cpu_quirk_pkg;
    typedef enum logic [2:0] {
        KIND_OTHER,
        KIND_JUMP,
        KIND_COND_JUMP,
        KIND_POP_MULTI,
        KIND_ERASE_INFO_D
    } instr_kind_type;
endpackage

// file: stray_read_if.sv
// Carrier between the retire logic and the stray read unit
`timescale 1ns/1ps
interface stray_read_if;
    logic popMultiDone;
    logic [19:0] finalSp;
    logic vacantFlag;
    logic vacantIrq;
    logic rdReq;
    logic [19:0] rdAddr;
    modport retire
    (
        output popMultiDone,
        output finalSp,
        input vacantFlag,
        input vacantIrq,
        input rdReq,
        input rdAddr
    );
    modport unit
    (
        input popMultiDone,
        input finalSp,
        output vacantFlag,
        output vacantIrq,
        output rdReq,
        output rdAddr
    );
endinterface

// file: stray_read_unit.sv
// Extra read after pop-multiple and the vacant-access flag it can raise
`timescale 1ns/1ps
`include "cpu_quirk_map.svh"
module stray_read_unit
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Retire side
    stray_read_if.unit sr,
    // Memory answer and flag control
    input wire logic rdVacant,
    input wire logic vacantFlagClear,
    input wire logic vacantIrqEnable
);
    logic rdReq_q, rdReq_d;
    logic [19:0] rdAddr_q, rdAddr_d;
    logic flag_q, flag_d;
    logic irq_q, irq_d;

    always_comb
    begin
        rdReq_d = sr.popMultiDone;
        rdAddr_d = sr.popMultiDone ? sr.finalSp : rdAddr_q;
        flag_d = (rdReq_q && rdVacant) ? 1'b1 : (vacantFlagClear ? 1'b0 : flag_q);
        irq_d = flag_d && vacantIrqEnable;
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rdReq_q <= 1'b0;
            rdAddr_q <= `QUIRK_ADDR_RESET;
            flag_q <= 1'b0;
            irq_q <= 1'b0;
        end
        else
        begin
            rdReq_q <= rdReq_d;
            rdAddr_q <= rdAddr_d;
            flag_q <= flag_d;
            irq_q <= irq_d;
        end
    end

    // read data never used; only the vacancy answer is looked at
    assign sr.rdReq = rdReq_q;
    assign sr.rdAddr = rdAddr_q;
    assign sr.vacantFlag = flag_q;
    assign sr.vacantIrq = irq_q;

    property p_stray_follows_pop_multi;
        @(posedge clk) disable iff (!rst_n)
        sr.popMultiDone |=> rdReq_q && rdAddr_q == $past(sr.finalSp);
    endproperty
    a_stray_follows_pop_multi: assert property (p_stray_follows_pop_multi)
        else $error("no stray read after pop-multiple");

    property p_vacant_sets_flag;
        @(posedge clk) disable iff (!rst_n)
        rdReq_q && rdVacant |=> flag_q;
    endproperty
    a_vacant_sets_flag: assert property (p_vacant_sets_flag)
        else $error("vacant stray read did not set flag");

    property p_irq_when_enabled;
        @(posedge clk) disable iff (!rst_n)
        rdReq_q && rdVacant && vacantIrqEnable |=> irq_q;
    endproperty
    a_irq_when_enabled: assert property (p_irq_when_enabled)
        else $error("vacant interrupt not raised");

    property p_read_only_after_pop_multi;
        @(posedge clk) disable iff (!rst_n)
        rdReq_q |-> $past(sr.popMultiDone);
    endproperty
    a_read_only_after_pop_multi: assert property (p_read_only_after_pop_multi)
        else $error("stray read without pop-multiple");
endmodule

// file: stack_mem_model.sv
// Memory decoder answering the stray read with its vacancy
`timescale 1ns/1ps
module stack_mem_model
#(
    parameter logic [19:0] STACK_TOP = 20'h0_2400
)
(
    // Clock
    input wire logic clk,
    // Stray read
    input wire logic rdReq,
    input wire logic [19:0] rdAddr,
    output logic rdVacant
);
    logic junk_q = 1'b0;
    always @(posedge clk)
        junk_q <= ~junk_q;
    // vacant at or above top
    // Unselected answer keeps changing so no stale level is trusted
    assign rdVacant = rdReq ? (rdAddr >= STACK_TOP) : junk_q;
endmodule

// file: cpu_jump_and_pop_multiple_quirks_tb_top.sv
// Self-checking bench for the jump and pop-multiple anomaly model
`timescale 1ns/1ps
`include "cpu_quirk_map.svh"
module cpu_jump_and_pop_multiple_quirks_tb_top;
    import cpu_quirk_pkg::*;
    localparam logic [19:0] TOP = 20'h0_2400;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic retValid = 1'b0;
    instr_kind_type retKind = KIND_OTHER;
    logic [19:0] retPc = '0, retNextPc = '0, loopStart = '0, popMultiFinalSp = '0;
    logic [15:0] followWord = '0;
    logic [15:0] patWords [5] = '{16'h0040, 16'h0F50, 16'h0A40, 16'h0041, 16'h1050};
    logic condFalse = 1'b0, debugStep = 1'b0, vacantFlagClear = 1'b0, vacantIrqEnable = 1'b0;
    logic rdVacant, traceValid_q, strayRdReq_q, vacantFlag_q, vacantIrq_q;
    logic [19:0] pc_q, traceAddr_q, strayRdAddr_q, lastLoop = '0;
    logic loopExit = 1'b0;
    logic [39:0] expQ[$];
    logic [39:0] got;
    logic [19:0] strayQ[$];
    logic [31:0] seed = 32'h0000_ccb1;
    int miscompares = 0;
    int total_checks = 0;
    always #20 clk = ~clk;
    cpu_quirk_core dut (.clk(clk), .rst_n(rst_n), .retValid(retValid), .retKind(retKind),
        .retPc(retPc), .retNextPc(retNextPc), .followWord(followWord), .condFalse(condFalse),
        .loopStart(loopStart), .popMultiFinalSp(popMultiFinalSp), .debugStep(debugStep),
        .rdVacant(rdVacant), .vacantFlagClear(vacantFlagClear),
        .vacantIrqEnable(vacantIrqEnable), .pc_q(pc_q), .traceValid_q(traceValid_q),
        .traceAddr_q(traceAddr_q), .strayRdReq_q(strayRdReq_q),
        .strayRdAddr_q(strayRdAddr_q), .vacantFlag_q(vacantFlag_q), .vacantIrq_q(vacantIrq_q));
    stack_mem_model #(.STACK_TOP(TOP)) mem (.clk(clk), .rdReq(strayRdReq_q),
        .rdAddr(strayRdAddr_q), .rdVacant(rdVacant));
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    task automatic check(input logic [19:0] seen, input logic [19:0] exp);
        total_checks++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic conclude();
        $display("checks %0d mismatches %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    // Expectations are taken after the edge so earlier updates have landed
    task automatic retire(input instr_kind_type k, input logic [19:0] pc, input logic [15:0] fw,
        input logic cf, input logic [19:0] sp);
        logic [19:0] e;
        @(posedge clk);
        e = pc + `QUIRK_PC_STEP;
        if ((k == KIND_JUMP || k == KIND_COND_JUMP) && ((fw & `QUIRK_FOLLOW_MASK) ==
            `QUIRK_FOLLOW_PAT_A || (fw & `QUIRK_FOLLOW_MASK) == `QUIRK_FOLLOW_PAT_B))
            e = e + `QUIRK_PC_STEP;
        if (k == KIND_ERASE_INFO_D && debugStep)
            e = e ^ `QUIRK_CORRUPT_MASK;
        expQ.push_back({e, loopExit ? lastLoop : pc});
        loopExit = (k == KIND_COND_JUMP) && cf;
        lastLoop = pc - 20'h0_0008;
        if (k == KIND_POP_MULTI)
            strayQ.push_back(sp);
        retValid <= 1'b1;
        retKind <= k;
        retPc <= pc;
        retNextPc <= pc + `QUIRK_PC_STEP;
        followWord <= fw;
        condFalse <= cf;
        loopStart <= pc - 20'h0_0008;
        popMultiFinalSp <= sp;
    endtask
    task automatic idle();
        @(posedge clk);
        retValid <= 1'b0;
    endtask
    task automatic popMulti(input logic [19:0] sp, input logic en, input logic flag);
        vacantIrqEnable <= en;
        retire(KIND_POP_MULTI, 20'h0_8100, 16'h0000, 1'b0, sp);
        idle();
        repeat (2) @(posedge clk);
        #1;
        check(20'(vacantFlag_q), 20'(flag));
        check(20'(vacantIrq_q), 20'(flag & en));
        check(pc_q, 20'h0_8102);
        @(posedge clk);
        vacantFlagClear <= 1'b1;
        @(posedge clk);
        vacantFlagClear <= 1'b0;
    endtask
    // Outputs looked at mid-cycle, well clear of the edge that launches them
    always @(negedge clk)
    begin
        if (traceValid_q === 1'b1)
        begin
            got = expQ.size() > 0 ? expQ.pop_front() : '1;
            check(pc_q, got[39:20]);
            check(traceAddr_q, got[19:0]);
        end
        if (strayRdReq_q === 1'b1)
            check(strayRdAddr_q, strayQ.size() > 0 ? strayQ.pop_front() : '1);
    end
    initial
    begin
        #(40 * 3000);
        miscompares++;
        conclude();
    end
    initial
    begin
        repeat (20) @(posedge clk);
        rst_n <= 1'b1;
        for (int i = 0; i < 30; i++)
        begin
            seed = lfsr(seed);
            retire(instr_kind_type'(seed[1:0]), {seed[19:1], 1'b0}, seed[31:16], seed[2], '0);
        end
        for (int j = 0; j < 5; j++)
        begin
            seed = lfsr(seed);
            retire(KIND_JUMP, 20'h0_9000, patWords[j] | {4'h0, seed[3:0], 8'h00}, 1'b0, '0);
        end
        retire(KIND_JUMP, 20'h0_9010, 16'h0000, 1'b0, '0);
        retire(KIND_COND_JUMP, 20'h0_8016, 16'h0140, 1'b1, '0);
        retire(KIND_OTHER, 20'h0_801A, 16'h0000, 1'b0, '0);
        retire(KIND_COND_JUMP, 20'h0_8016, 16'h0000, 1'b1, '0);
        retire(KIND_OTHER, 20'h0_8018, 16'h0000, 1'b0, '0);
        idle();
        debugStep <= 1'b1;
        retire(KIND_ERASE_INFO_D, 20'h0_8200, 16'h0000, 1'b0, '0);
        idle();
        debugStep <= 1'b0;
        retire(KIND_ERASE_INFO_D, 20'h0_8200, 16'h0000, 1'b0, '0);
        idle();
        popMulti(TOP, 1'b1, 1'b1);
        popMulti(TOP - 20'h0_0004, 1'b1, 1'b0);
        popMulti(TOP - 20'h0_0002, 1'b1, 1'b0);
        popMulti(TOP, 1'b0, 1'b1);
        #1;
        check(20'(vacantFlag_q), 20'h0_0000);
        check(20'(expQ.size() + strayQ.size()), 20'h0_0000);
        conclude();
    end
endmodule
